// ### dsp_pkg.sv
// Shared constants and types for the data strobe pin control block
package dsp_pkg;
  // ----------------------------------------------------------------
  // Extended mode register fields
  // ----------------------------------------------------------------
  localparam int EMR_COMP_DIS_BIT = 10;
  localparam int EMR_RDQS_EN_BIT  = 11;
  localparam int EMR_OP_W         = 13;

  // ----------------------------------------------------------------
  // Reset values and burst shape
  // ----------------------------------------------------------------
  localparam logic       RST_DIFF_EN = 1'b0;
  localparam logic       RST_RDQS_EN = 1'b0;
  localparam logic [2:0] BURST_BEATS = 3'h4;
  localparam int         LANE_SYNC_W = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFG_X4  = 2'h0,
    CFG_X8  = 2'h1,
    CFG_X16 = 2'h2
  } dsp_width_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WRITE = 2'h2
  } dsp_state_t;
endpackage

// ### dsp_lane_if.sv
// Signals between the strobe controller and one byte capture lane
`timescale 1ns/1ps
interface dsp_lane_if;
  logic       strobeIn;
  logic [7:0] dqIn;
  logic       dmIn;
  logic       enable;
  logic       useMask;
  logic       capEdge;
  logic       capValid;
  logic [7:0] capData;

  modport lane (input strobeIn, dqIn, dmIn, enable, useMask,
                output capEdge, capValid, capData);
  modport ctrl (output strobeIn, dqIn, dmIn, enable, useMask,
                input capEdge, capValid, capData);
endinterface

// ### dsp_strobe_lane.sv
// One byte lane: samples its own write strobe, data and mask pins
`timescale 1ns/1ps
module dsp_strobe_lane import dsp_pkg::*; (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Controller side
  dsp_lane_if.lane  lane
);
  typedef struct packed {
    logic [LANE_SYNC_W-1:0] s1;
    logic [LANE_SYNC_W-1:0] s2;
    logic [LANE_SYNC_W-1:0] s3;
    logic                   lvl;
    logic                   edgeP;
    logic                   capValid;
    logic [7:0]             capData;
  } dsp_lane_state_t;

  dsp_lane_state_t st_q;
  dsp_lane_state_t st_d;
  logic            strobeEdge;

  // Bit 9 mask, bit 8 strobe, bits 7:0 data; all three stages move together
  assign strobeEdge = (st_q.s2[8] == st_q.s3[8]) && (st_q.s3[8] != st_q.lvl);

  always_comb begin
    st_d          = st_q;
    st_d.s1       = {lane.dmIn, lane.strobeIn, lane.dqIn};
    st_d.s2       = st_q.s1;
    st_d.s3       = st_q.s2;
    st_d.edgeP    = 1'b0;
    st_d.capValid = 1'b0;
    if (strobeEdge) begin
      st_d.lvl = st_q.s3[8];
      // Both strobe edges take a beat; the mask is sampled with it
      if (lane.enable) begin
        st_d.edgeP = 1'b1;
        if (!(lane.useMask && st_q.s3[9])) begin
          st_d.capValid = 1'b1;
          st_d.capData  = st_q.s3[7:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lane.capEdge  = st_q.edgeP;
  assign lane.capValid = st_q.capValid;
  assign lane.capData  = st_q.capData;

  masked_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    (lane.enable && lane.useMask && strobeEdge && st_q.s3[9])
      |=> (st_q.edgeP && !st_q.capValid))
    else $error("masked write beat was not discarded");

  beat_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
    (lane.enable && strobeEdge && !st_q.s3[9])
      |=> (st_q.capValid && st_q.capData == $past(st_q.s3[7:0])))
    else $error("unmasked write beat lost or wrong");
endmodule

// ### dsp_strobe_ctrl.sv
// Data strobe pin control for a DDR2 memory device data interface
`timescale 1ns/1ps
module dsp_strobe_ctrl import dsp_pkg::*; (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Configuration and extended mode load
  input  wire dsp_width_t          cfgWidth,
  input  wire logic                emrLoad,
  input  wire logic [EMR_OP_W-1:0] emrOp,
  // Core read side
  input  wire logic                rdStart,
  input  wire logic [15:0]         rdBeat,
  output wire logic                rdTake,
  // Core write side
  input  wire logic                wrStart,
  output wire logic [15:0]         wrData,
  output wire logic [1:0]          wrByteValid,
  output wire logic                busy,
  // Link clock
  input  wire logic                ck,
  // Data and mask pins
  input  wire logic [15:0]         dqIn,
  output wire logic [15:0]         dqOut,
  output wire logic [1:0]          dqDrvN,
  input  wire logic                ldmIn,
  input  wire logic                udmIn,
  // Lower strobe pair
  input  wire logic                ldqsIn,
  output wire logic                ldqsOut,
  output wire logic                ldqsDrvN,
  output wire logic                ldqsCompOut,
  output wire logic                ldqsCompDrvN,
  // Upper strobe pair
  input  wire logic                udqsIn,
  output wire logic                udqsOut,
  output wire logic                udqsDrvN,
  output wire logic                udqsCompOut,
  output wire logic                udqsCompDrvN,
  // Redundant strobe pair
  output wire logic                rdqsOut,
  output wire logic                rdqsDrvN,
  output wire logic                rdqsCompOut,
  output wire logic                rdqsCompDrvN
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dsp_state_t  state;
    logic        diffEn;
    logic        rdqsEn;
    logic        ckS1;
    logic        ckS2;
    logic        ckS3;
    logic        ckLvl;
    logic [2:0]  beatCnt;
    logic [15:0] dqOut;
    logic        strobe;
  } dsp_top_state_t;

  localparam dsp_top_state_t ST_RST = '{
    state:   ST_IDLE,
    diffEn:  RST_DIFF_EN,
    rdqsEn:  RST_RDQS_EN,
    ckS1:    1'b0,
    ckS2:    1'b0,
    ckS3:    1'b0,
    ckLvl:   1'b0,
    beatCnt: 3'h0,
    dqOut:   16'h0000,
    strobe:  1'b0
  };

  dsp_top_state_t st_q;
  dsp_top_state_t st_d;
  logic           ckEdge;
  logic           reading;
  logic           isX8;
  logic           isX16;

  dsp_lane_if lowIf ();
  dsp_lane_if upIf ();

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  // Each lane sees only its own strobe, data byte and mask
  assign lowIf.strobeIn = ldqsIn;
  assign lowIf.dqIn     = dqIn[7:0];
  assign lowIf.dmIn     = ldmIn;
  assign lowIf.enable   = (st_q.state == ST_WRITE);
  // On x8 the mask ball doubles as the redundant strobe; once that is on,
  // nothing drives a mask there during writes, so the ball is disregarded
  assign lowIf.useMask  = !(isX8 && st_q.rdqsEn);
  assign upIf.strobeIn  = udqsIn;
  assign upIf.dqIn      = dqIn[15:8];
  assign upIf.dmIn      = udmIn;
  assign upIf.enable    = (st_q.state == ST_WRITE) && isX16;
  assign upIf.useMask   = 1'b1;

  dsp_strobe_lane lowLane (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lane    (lowIf)
  );

  dsp_strobe_lane upLane (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lane    (upIf)
  );

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  // CK is asynchronous to sys_clk; both its edges pace read beats
  assign ckEdge = (st_q.ckS2 == st_q.ckS3) && (st_q.ckS3 != st_q.ckLvl);
  assign isX8   = (cfgWidth == CFG_X8);
  assign isX16  = (cfgWidth == CFG_X16);

  always_comb begin
    st_d      = st_q;
    st_d.ckS1 = ck;
    st_d.ckS2 = st_q.ckS1;
    st_d.ckS3 = st_q.ckS2;
    if (ckEdge) begin
      st_d.ckLvl = st_q.ckS3;
    end
    case (st_q.state)
      ST_IDLE: begin
        // Mode loads only take effect between bursts
        if (emrLoad) begin
          st_d.diffEn = !emrOp[EMR_COMP_DIS_BIT];
          st_d.rdqsEn = emrOp[EMR_RDQS_EN_BIT];
        end
        if (rdStart) begin
          st_d.state   = ST_READ;
          st_d.beatCnt = 3'h0;
          st_d.strobe  = 1'b0;
        end else if (wrStart) begin
          st_d.state   = ST_WRITE;
          st_d.beatCnt = 3'h0;
        end
      end
      ST_READ: begin
        if (ckEdge) begin
          if (st_q.beatCnt == BURST_BEATS) begin
            st_d.state = ST_IDLE;
          end else begin
            // Data and strobe flip in the same cycle: edge aligned
            st_d.dqOut   = rdBeat;
            st_d.strobe  = !st_q.strobe;
            st_d.beatCnt = st_q.beatCnt + 3'h1;
          end
        end
      end
      ST_WRITE: begin
        // Lower lane strobe edges count the burst, masked beats included
        if (lowIf.capEdge) begin
          st_d.beatCnt = st_q.beatCnt + 3'h1;
          if (st_q.beatCnt == BURST_BEATS - 3'h1) begin
            st_d.state = ST_IDLE;
          end
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reading      = (st_q.state == ST_READ);
  assign rdTake       = reading && ckEdge && (st_q.beatCnt != BURST_BEATS);
  assign busy         = (st_q.state != ST_IDLE);
  assign wrData       = {upIf.capData, lowIf.capData};
  assign wrByteValid  = {upIf.capValid, lowIf.capValid};
  assign dqOut        = st_q.dqOut;
  // Device drives strobes and data only while reading; writes leave pins to the controller
  assign dqDrvN       = {!(reading && isX16), !reading};
  assign ldqsOut      = st_q.strobe;
  assign ldqsDrvN     = !reading;
  assign ldqsCompOut  = !st_q.strobe;
  assign ldqsCompDrvN = !(reading && st_q.diffEn);
  assign udqsOut      = st_q.strobe;
  assign udqsDrvN     = !(reading && isX16);
  assign udqsCompOut  = !st_q.strobe;
  assign udqsCompDrvN = !(reading && isX16 && st_q.diffEn);
  assign rdqsOut      = st_q.strobe;
  assign rdqsDrvN     = !(reading && isX8 && st_q.rdqsEn);
  assign rdqsCompOut  = !st_q.strobe;
  assign rdqsCompDrvN = !(reading && isX8 && st_q.rdqsEn && st_q.diffEn);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  read_edge_align_a: assert property (@(posedge sys_clk) disable iff (rst)
    rdTake |=> (ldqsOut != $past(ldqsOut)) && (dqOut == $past(rdBeat)))
    else $error("read strobe edge not aligned with read data");

  read_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q.state == ST_IDLE && rdStart) |=> (!ldqsDrvN && !dqDrvN[0]) [*2])
    else $error("device not driving strobe with read data");

  write_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q.state == ST_WRITE) |-> (ldqsDrvN && udqsDrvN && rdqsDrvN && dqDrvN == 2'h3))
    else $error("device drove pins during a write");

  upper_lane_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!udqsDrvN || upIf.enable) |-> isX16)
    else $error("upper strobe used outside sixteen-bit mode");

  comp_disable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q.state == ST_IDLE && emrLoad && emrOp[EMR_COMP_DIS_BIT])
      |=> (ldqsCompDrvN && udqsCompDrvN && rdqsCompDrvN) [*2])
    else $error("complement strobe driven while disabled");

  comp_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
    !ldqsCompDrvN |-> (st_q.diffEn && !ldqsDrvN && ldqsCompOut == !ldqsOut))
    else $error("complement strobe driven without differential mode");

  rdqs_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rdqsDrvN |-> (reading && isX8 && st_q.rdqsEn && rdqsOut == ldqsOut))
    else $error("redundant strobe driven outside an x8 read");

  rdqs_comp_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rdqsCompDrvN |-> (st_q.rdqsEn && st_q.diffEn && !rdqsDrvN))
    else $error("redundant complement strobe driven when not enabled");

  mask_ball_a: assert property (@(posedge sys_clk) disable iff (rst)
    (isX8 && !st_q.rdqsEn) |-> (lowIf.useMask && rdqsDrvN))
    else $error("shared ball not treated as mask with redundant strobe off");
endmodule

// ### dsp_ctrl_model.sv
// Memory controller model: link clock, write strobes, write data and masks
`timescale 1ns/1ps
module dsp_ctrl_model import dsp_pkg::*; (
  // Clocks
  input  wire logic   sys_clk,
  output logic        ck,
  // Write side pins
  output logic [15:0] dqIn,
  output logic        ldmIn,
  output logic        udmIn,
  output logic        ldqsIn,
  output logic        udqsIn
);
  initial begin
    dqIn = 16'h0000;
    ldmIn = 1'b0;
    udmIn = 1'b0;
    ldqsIn = 1'b0;
    udqsIn = 1'b0;
  end

  // CK runs free; the offset keeps its phase unrelated to sys_clk
  initial begin
    ck = 1'b0;
    #7;
    forever #80 ck = ~ck;
  end

  // ----------------------------------------------------------------
  // Write burst
  // ----------------------------------------------------------------
  // Data settles four cycles before each strobe edge and holds five after
  task automatic send(input logic [3:0] lm, input logic [3:0] um, input logic upOn);
    int k;
    for (k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      dqIn <= {8'h50 + 8'(k), 8'hA0 + 8'(k)};
      ldmIn <= lm[k];
      udmIn <= um[k];
      repeat (4) @(posedge sys_clk);
      ldqsIn <= ~ldqsIn;
      if (upOn) udqsIn <= ~udqsIn;
      repeat (4) @(posedge sys_clk);
    end
    // Released lines must not keep showing the last beat
    @(posedge sys_clk);
    dqIn <= ~dqIn;
    ldmIn <= ~ldmIn;
    udmIn <= ~udmIn;
  endtask
endmodule

// ### dsp_strobe_ctrl_tb_top.sv
// Self-checking testbench for the data strobe pin control block
`timescale 1ns/1ps
module dsp_strobe_ctrl_tb_top import dsp_pkg::*;;
  dsp_width_t          cfgWidth;
  logic                sys_clk, rst, emrLoad, rdStart, wrStart, ck, busy, rdTake;
  logic [EMR_OP_W-1:0] emrOp;
  logic [15:0]         rdBeat, wrData, dqIn, dqOut;
  logic [1:0]          wrByteValid, dqDrvN;
  logic                ldmIn, udmIn, ldqsIn, udqsIn, ldqsOut, ldqsDrvN, ldqsCompOut;
  logic                ldqsCompDrvN, udqsOut, udqsDrvN, udqsCompOut, udqsCompDrvN;
  logic                rdqsOut, rdqsDrvN, rdqsCompOut, rdqsCompDrvN;
  int                  mismatches, comparisons;
  wire logic [7:0]     drv = {dqDrvN, ldqsDrvN, ldqsCompDrvN, udqsDrvN, udqsCompDrvN,
                              rdqsDrvN, rdqsCompDrvN};
  wire logic [5:0]     strb = {ldqsOut, ldqsCompOut, udqsOut, udqsCompOut, rdqsOut,
                               rdqsCompOut};

  dsp_strobe_ctrl u_dut (
    .sys_clk, .rst, .cfgWidth, .emrLoad, .emrOp, .rdStart, .rdBeat, .rdTake, .wrStart,
    .wrData, .wrByteValid, .busy, .ck, .dqIn, .dqOut, .dqDrvN, .ldmIn, .udmIn, .ldqsIn,
    .ldqsOut, .ldqsDrvN, .ldqsCompOut, .ldqsCompDrvN, .udqsIn, .udqsOut, .udqsDrvN,
    .udqsCompOut, .udqsCompDrvN, .rdqsOut, .rdqsDrvN, .rdqsCompOut, .rdqsCompDrvN
  );
  dsp_ctrl_model u_mem (.sys_clk, .ck, .dqIn, .ldmIn, .udmIn, .ldqsIn, .udqsIn);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic load(input dsp_width_t wd, input logic [EMR_OP_W-1:0] op);
    @(posedge sys_clk);
    cfgWidth <= wd;
    emrLoad <= 1'b1;
    emrOp <= op;
    @(posedge sys_clk);
    emrLoad <= 1'b0;
  endtask

  task automatic idle_wait();
    int t;
    for (t = 0; t < 60 && busy !== 1'b0; t++) @(negedge sys_clk);
    chk(16'(busy), 16'h0000);
    chk(16'(drv), 16'h00FF);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // One beat per CK edge; the strobe toggles in the cycle the beat appears
  task automatic read_burst(input dsp_width_t wd, input logic [EMR_OP_W-1:0] op,
                            input logic [7:0] drvExp);
    int t;
    int n;
    logic st;
    load(wd, op);
    rdStart <= 1'b1;
    @(posedge sys_clk);
    rdStart <= 1'b0;
    st = 1'b0;
    n = 0;
    for (t = 0; t < 200 && n < 4; t++) begin
      @(negedge sys_clk);
      if (rdTake === 1'b1) begin
        chk(16'(drv), 16'(drvExp));
        @(negedge sys_clk);
        st = ~st;
        chk(dqOut, rdBeat);
        chk(16'(strb), 16'({3{st, ~st}}));
        n++;
        @(posedge sys_clk);
        rdBeat <= rdBeat + 16'h1111;
      end
    end
    chk(16'(n), 16'h0004);
    idle_wait();
  endtask

  // Masked beats give no valid pulse unless honor is clear (x8 with the redundant strobe on); the upper lane moves only on x16
  task automatic write_burst(input dsp_width_t wd, input logic [EMR_OP_W-1:0] op,
                             input logic [3:0] lm, input logic [3:0] um, input logic honor);
    logic [7:0] ql[$];
    logic [7:0] qu[$];
    logic [7:0] e;
    int k;
    int t;
    for (k = 0; k < 4; k++) begin
      if (!(lm[k] && honor)) ql.push_back(8'hA0 + 8'(k));
      if (wd == CFG_X16 && !um[k]) qu.push_back(8'h50 + 8'(k));
    end
    load(wd, op);
    wrStart <= 1'b1;
    @(posedge sys_clk);
    wrStart <= 1'b0;
    fork
      u_mem.send(lm, um, wd == CFG_X16);
      for (t = 0; t < 60; t++) begin
        @(negedge sys_clk);
        if (t == 20) chk(16'(drv), 16'h00FF);
        if (wrByteValid[0] === 1'b1) begin
          e = ql.size() > 0 ? ql.pop_front() : 8'hEE;
          chk(16'(wrData[7:0]), 16'(e));
        end
        if (wrByteValid[1] === 1'b1) begin
          e = qu.size() > 0 ? qu.pop_front() : 8'hEE;
          chk(16'(wrData[15:8]), 16'(e));
        end
      end
    join
    chk(16'(ql.size() + qu.size()), 16'h0000);
    idle_wait();
  endtask

  // A reset in mid-read drops the burst and both mode bits
  task automatic reset_mid();
    int t;
    logic [7:0] e;
    load(CFG_X8, 13'h0800);
    rdStart <= 1'b1;
    @(posedge sys_clk);
    rdStart <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(16'(busy), 16'h0000);
    chk(16'(drv), 16'h00FF);
    chk(16'(strb), 16'h0015);
    chk(dqOut, 16'h0000);
    @(posedge sys_clk);
    rdStart <= 1'b1;
    @(posedge sys_clk);
    rdStart <= 1'b0;
    @(negedge sys_clk);
    for (t = 0; t < 20 && rdTake !== 1'b1; t++) @(negedge sys_clk);
    chk(16'(rdTake), 16'h0001);
    e = {2'b10, 1'b0, !RST_DIFF_EN, 2'b11, !RST_RDQS_EN, !(RST_RDQS_EN && RST_DIFF_EN)};
    chk(16'(drv), 16'(e));
    idle_wait();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #200_000;
    mismatches++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    cfgWidth = CFG_X16;
    emrLoad = 1'b0;
    emrOp = '0;
    rdStart = 1'b0;
    wrStart = 1'b0;
    rdBeat = 16'h1234;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    idle_wait();
    chk(16'(strb), 16'h0015);
    read_burst(CFG_X16, 13'h0000, 8'h03);
    read_burst(CFG_X16, 13'h0400, 8'h17);
    read_burst(CFG_X8, 13'h0800, 8'h8C);
    read_burst(CFG_X8, 13'h0C00, 8'h9D);
    read_burst(CFG_X4, 13'h0000, 8'h8F);
    write_burst(CFG_X16, 13'h0000, 4'h8, 4'h2, 1'b1);
    write_burst(CFG_X8, 13'h0000, 4'h5, 4'h0, 1'b1);
    write_burst(CFG_X8, 13'h0800, 4'h5, 4'h0, 1'b0);
    reset_mid();
    close_out();
  end
endmodule
